// ### logic/serial_port_pkg.sv
`default_nettype none
package serial_port_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_FRAME_FORMAT = 6'h32;
  localparam logic [5:0] IDX_SLOT_XY = 6'h33;
  localparam logic [5:0] IDX_SLOT_ZT = 6'h34;
  localparam logic [5:0] IDX_STATUS = 6'h3F;

  localparam logic [7:0] RST_FRAME_FORMAT = 8'h00;
  localparam logic [7:0] RST_SLOT_XY = 8'h08;
  localparam logic [7:0] RST_SLOT_ZT = 8'h1A;

  // serial_frame_format fields
  localparam int WIDTH_LSB = 6;
  localparam int BCLK_INV_BIT = 5;
  localparam int FS_INV_BIT = 4;
  localparam int FS_STYLE_BIT = 3;
  localparam int FORMAT_LSB = 0;
  // serial_slot_assign_xy fields
  localparam int FILL_BIT = 7;
  localparam int HIZ_BIT = 6;
  localparam int SLOT_HI_LSB = 3;
  localparam int SLOT_LO_LSB = 0;
  // serial_slot_assign_zt fields
  localparam int PIN_SEL_BIT = 7;
  localparam int DUAL_BIT = 6;
  // status fields
  localparam int STAT_PEND_BIT = 0;
  localparam int STAT_PHASE_LSB = 1;
  localparam int STAT_FRAMES_LSB = 8;

  localparam logic [1:0] WCODE_16 = 2'h1;
  localparam logic [1:0] WCODE_24 = 2'h2;
  localparam logic [5:0] SLOT_BITS_32 = 6'h20;
  localparam logic [5:0] SLOT_BITS_16 = 6'h10;
  localparam logic [5:0] SLOT_BITS_24 = 6'h18;

  localparam logic [2:0] FMT_I2S = 3'h0;
  localparam logic [2:0] FMT_LJ = 3'h1;
  localparam logic [2:0] FMT_D8 = 3'h2;
  localparam logic [2:0] FMT_D12 = 3'h3;
  localparam logic [2:0] FMT_D16 = 3'h4;
  localparam logic [4:0] DLY_I2S = 5'h01;
  localparam logic [4:0] DLY_LJ = 5'h00;
  localparam logic [4:0] DLY_8 = 5'h08;
  localparam logic [4:0] DLY_12 = 5'h0C;
  localparam logic [4:0] DLY_16 = 5'h10;

  localparam int SAMPLE_W = 16;
  localparam int NUM_CH = 4;
  localparam logic [2:0] LAST_TDM_SLOT = 3'h7;

  typedef enum logic [1:0] {
    PH_WAIT = 2'b00,
    PH_DELAY = 2'b01,
    PH_DATA = 2'b11,
    PH_DONE = 2'b10
  } phase_t;

  // ch[0] X, ch[1] Y, ch[2] Z, ch[3] temperature
  typedef struct packed {
    logic [NUM_CH-1:0][SAMPLE_W-1:0] ch;
  } sample_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic serial_out_a;
    logic serial_out_a_oe;
    logic serial_out_b;
    logic serial_out_b_oe;
  } serial_pins_t;

endpackage : serial_port_pkg
`default_nettype wire

// ### logic/accel_audio_serial_port.sv
// Functional notes
// [R1] Slot width code 00/01/10 gives 32/16/24 bit clocks per slot.
// [R2] Bit clock invert 0 uses bit clock as is, 1 inverts it.
// [R3] Frame sync invert 0 uses frame sync as is, 1 inverts it.
// [R4] Frame sync style 0: frame sync is a 50 percent stereo clock.
// [R5] Frame sync style 1: TDM, frame sync is one bit-clock pulse.
// [R6] Data format sets first-bit delay: 1, 0, 8, 12 or 16 bit clocks.
// [R7] Fill 0: fresh sample for one frame, then zeros until next sample.
// [R8] Fill 1: fresh sample for one frame, then repeat it until next.
// [R9] Hi-Z enable 1 lets idle serial data float; 0 always drives. Both pins float from reset until the first launch edge.
// [R10] Stereo: slot 0/1 is left/right; in dual mode 0/1 go on pin a, 2/3 on pin b.
// [R11] TDM: slot value 0 to 7 picks that TDM slot of the frame.
// [R12] X sample goes to its 3-bit slot field, reset value 0.
// [R13] Y sample goes to its 3-bit slot field, reset value 1.
// [R14] Z sample goes to its 3-bit slot field, reset value 2.
// [R15] Temperature sample goes to its 3-bit slot field, reset value 3.
// [R16] Pin select 0 streams on pin a, 1 streams on pin b.
// [R17] Dual mode: slots 0 and 1 on pin a, slots 2 and 3 on pin b.
// [R18] Dual stereo: channels assigned to slots 2 and 3 leave on the second data pin.
// [R19] Dual mode off: enabled channels leave on the one selected pin; stereo slots 2/3 are dropped.
// [R20] Reserved width and format codes fall back to 32 bits and delay 1.
// [R21] Samples go out MSB first, slot bits after the word are zero.
`timescale 1ns/100ps
`default_nettype none
module accel_audio_serial_port
  import serial_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire apb_req_t apb_req,
  output apb_rsp_t apb_rsp,
  input wire logic bit_clock,
  input wire logic frame_sync,
  input wire logic sample_valid,
  input wire sample_t sample_in,
  output serial_pins_t pins
);

  typedef struct packed {
    logic [7:0] fmt_reg;
    logic [7:0] xy_reg;
    logic [7:0] zt_reg;
    logic bclk_s1;
    logic bclk_s2;
    logic bclk_s3;
    logic fs_s1;
    logic fs_s2;
    logic fs_last;
    phase_t phase;
    logic [4:0] dly;
    logic [4:0] bit_cnt;
    logic [2:0] slot;
    sample_t pend;
    logic pend_valid;
    sample_t frame;
    logic [7:0] frame_cnt;
    serial_pins_t pins;
    apb_rsp_t rsp;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic tdm;
  logic dual;
  logic [5:0] slot_bits;
  logic [4:0] delay;
  logic [NUM_CH-1:0][2:0] slot_field;
  logic [NUM_CH-1:0] ch_en;
  logic [NUM_CH-1:0] ch_pin_b;
  logic [NUM_CH-1:0][2:0] ch_slot;

  assign tdm = s_reg.fmt_reg[FS_STYLE_BIT];
  assign dual = s_reg.zt_reg[DUAL_BIT];
  assign slot_field[0] = s_reg.xy_reg[SLOT_LO_LSB +: 3]; // [R12]
  assign slot_field[1] = s_reg.xy_reg[SLOT_HI_LSB +: 3]; // [R13]
  assign slot_field[2] = s_reg.zt_reg[SLOT_LO_LSB +: 3]; // [R14]
  assign slot_field[3] = s_reg.zt_reg[SLOT_HI_LSB +: 3]; // [R15]

  always_comb
  begin
    unique case (s_reg.fmt_reg[WIDTH_LSB +: 2])
      WCODE_16: slot_bits = SLOT_BITS_16; // [R1]
      WCODE_24: slot_bits = SLOT_BITS_24; // [R1]
      default: slot_bits = SLOT_BITS_32; // [R1] [R20]
    endcase
  end

  always_comb
  begin
    unique case (s_reg.fmt_reg[FORMAT_LSB +: 3])
      FMT_I2S: delay = DLY_I2S; // [R6]
      FMT_LJ: delay = DLY_LJ; // [R6]
      FMT_D8: delay = DLY_8; // [R6]
      FMT_D12: delay = DLY_12; // [R6]
      FMT_D16: delay = DLY_16; // [R6]
      default: delay = DLY_I2S; // [R20]
    endcase
  end

  // Per-channel pin and slot routing
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++)
    begin : g_route
      always_comb
      begin
        if (dual)
        begin
          if (tdm)
          begin
            ch_pin_b[c] = (slot_field[c][2:1] == 2'h1); // [R17]
            ch_slot[c] = slot_field[c]; // [R11]
          end
          else
          begin
            ch_pin_b[c] = slot_field[c][1]; // [R10] [R18]
            ch_slot[c] = {2'h0, slot_field[c][0]}; // [R10]
          end
          ch_en[c] = 1'b1;
        end
        else
        begin
          ch_pin_b[c] = s_reg.zt_reg[PIN_SEL_BIT]; // [R16] [R19]
          // Without a second pin, stereo slots 2/3 have nowhere to go
          ch_en[c] = tdm | ~slot_field[c][1];
          ch_slot[c] = tdm ? slot_field[c]
                           : {2'h0, slot_field[c][0]}; // [R11] [R10]
        end
      end
    end
  endgenerate

  function automatic logic [31:0] read_reg(input logic [5:0] idx,
                                           input state_t st,
                                           output logic hit);
    logic [31:0] d;
    d = 32'h0000_0000;
    hit = 1'b1;
    unique case (idx)
      IDX_FRAME_FORMAT: d[7:0] = st.fmt_reg;
      IDX_SLOT_XY: d[7:0] = st.xy_reg;
      IDX_SLOT_ZT: d[7:0] = st.zt_reg;
      IDX_STATUS:
      begin
        d[STAT_PEND_BIT] = st.pend_valid;
        d[STAT_PHASE_LSB +: 2] = st.phase;
        d[STAT_FRAMES_LSB +: 8] = st.frame_cnt;
      end
      default: hit = 1'b0;
    endcase
    return d;
  endfunction : read_reg

  always_comb
  begin
    logic hit;
    logic [31:0] rdata;
    logic eff_now;
    logic eff_prev;
    logic fs_eff;
    logic start;
    logic left;
    logic own_a;
    logic own_b;
    logic bit_a;
    logic bit_b;
    logic dbit;
    phase_t ph;
    logic [4:0] dly;
    logic [4:0] bc;
    logic [2:0] sl;
    sample_t fr;
    hit = 1'b0;
    own_a = 1'b0;
    own_b = 1'b0;
    bit_a = 1'b0;
    bit_b = 1'b0;
    dbit = 1'b0;
    start = 1'b0;
    left = 1'b0;
    s_next = s_reg;

    // APB: one wait state, write lands on the edge that sees pready
    rdata = read_reg(apb_req.paddr[7:2], s_reg, hit);
    s_next.rsp.pready = 1'b0;
    if (apb_req.psel && apb_req.penable && !s_reg.rsp.pready)
    begin
      s_next.rsp.pready = 1'b1;
      s_next.rsp.pslverr = ~hit;
      s_next.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rdata;
    end
    if (apb_req.psel && apb_req.penable && s_reg.rsp.pready &&
        apb_req.pwrite && apb_req.pstrb[0])
    begin
      unique case (apb_req.paddr[7:2])
        IDX_FRAME_FORMAT: s_next.fmt_reg = apb_req.pwdata[7:0];
        IDX_SLOT_XY: s_next.xy_reg = apb_req.pwdata[7:0];
        IDX_SLOT_ZT: s_next.zt_reg = apb_req.pwdata[7:0];
        default: s_next.fmt_reg = s_reg.fmt_reg;
      endcase
    end

    // Pins are asynchronous; only the second and third stages feed any logic
    s_next.bclk_s1 = bit_clock;
    s_next.bclk_s2 = s_reg.bclk_s1;
    s_next.bclk_s3 = s_reg.bclk_s2;
    s_next.fs_s1 = frame_sync;
    s_next.fs_s2 = s_reg.fs_s1;

    if (sample_valid)
    begin
      s_next.pend = sample_in;
      s_next.pend_valid = 1'b1;
    end

    eff_now = s_reg.bclk_s2 ^ s_reg.fmt_reg[BCLK_INV_BIT]; // [R2]
    eff_prev = s_reg.bclk_s3 ^ s_reg.fmt_reg[BCLK_INV_BIT]; // [R2]
    fs_eff = s_reg.fs_s2 ^ s_reg.fmt_reg[FS_INV_BIT]; // [R3]
    ph = s_reg.phase;
    dly = s_reg.dly;
    bc = s_reg.bit_cnt;
    sl = s_reg.slot;
    fr = s_reg.frame;

    // Launch on the falling edge so the host samples on the rising one
    if (eff_prev && !eff_now)
    begin
      s_next.fs_last = fs_eff;
      if (tdm)
      begin
        start = fs_eff & ~s_reg.fs_last; // [R5]
        left = start;
      end
      else
      begin
        start = fs_eff ^ s_reg.fs_last; // [R4]
        left = start & ~fs_eff; // [R4]
      end
      if (start)
      begin
        dly = delay; // [R6]
        bc = 5'h00;
        sl = left ? 3'h0 : 3'h1;
        ph = (delay == DLY_LJ) ? PH_DATA : PH_DELAY;
      end
      if (left)
      begin
        s_next.frame_cnt = s_reg.frame_cnt + 8'h01;
        if (s_reg.pend_valid)
        begin
          fr = s_reg.pend;
          // A sample arriving now is kept for the next frame
          s_next.pend_valid = sample_valid;
        end
        else if (!s_reg.xy_reg[FILL_BIT])
          fr = '0; // [R7]
        // Fill 1 keeps the held frame unchanged [R8]
        s_next.frame = fr;
      end

      unique case (ph)
        PH_DELAY:
        begin
          dly = dly - 5'h01; // [R6]
          if (dly == 5'h00)
            ph = PH_DATA;
        end
        PH_DATA:
        begin
          for (int k = 0; k < NUM_CH; k++)
          begin
            if (ch_en[k] && ch_slot[k] == sl)
            begin
              // [R21]
              dbit = (bc < 5'(SAMPLE_W)) ?
                     fr.ch[k][4'(SAMPLE_W - 1) - bc[3:0]] : 1'b0;
              if (ch_pin_b[k])
              begin
                own_b = 1'b1;
                bit_b = bit_b | dbit;
              end
              else
              begin
                own_a = 1'b1;
                bit_a = bit_a | dbit;
              end
            end
          end
          if ({1'b0, bc} == slot_bits - 6'h01)
          begin
            bc = 5'h00; // [R1]
            if (!tdm || sl == LAST_TDM_SLOT)
              ph = PH_DONE;
            else
              sl = sl + 3'h1; // [R11]
          end
          else
            bc = bc + 5'h01;
        end
        default: ph = ph;
      endcase
      s_next.pins.serial_out_a = bit_a;
      s_next.pins.serial_out_b = bit_b;
      s_next.pins.serial_out_a_oe = own_a | ~s_reg.xy_reg[HIZ_BIT]; // [R9]
      s_next.pins.serial_out_b_oe = own_b | ~s_reg.xy_reg[HIZ_BIT]; // [R9]
    end
    s_next.phase = ph;
    s_next.dly = dly;
    s_next.bit_cnt = bc;
    s_next.slot = sl;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
      s_reg.fmt_reg <= RST_FRAME_FORMAT;
      s_reg.xy_reg <= RST_SLOT_XY;
      s_reg.zt_reg <= RST_SLOT_ZT;
    end
    else
      s_reg <= s_next;
  end

  assign apb_rsp = s_reg.rsp;
  assign pins = s_reg.pins;

endmodule : accel_audio_serial_port
`default_nettype wire

// ### test/serial_port_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module serial_port_assertions
  import serial_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire apb_req_t apb_req,
  input wire apb_rsp_t apb_rsp,
  input wire logic bit_clock,
  input wire serial_pins_t pins
);
  logic [3:0] quiet_reg;
  logic bc_reg;
  logic mapped;
  assign mapped = apb_req.paddr inside {8'hC8, 8'hCC, 8'hD0, 8'hFC};
  // Pin outputs may only move a few cycles after a link clock pin change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      quiet_reg <= 4'h0;
      bc_reg <= 1'b0;
    end
    else
    begin
      bc_reg <= bit_clock;
      quiet_reg <= (bit_clock != bc_reg) ? 4'h0
        : quiet_reg + {3'h0, quiet_reg != 4'hF};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  wait_state_a: assert property (apb_req.psel && apb_req.penable
    && !apb_rsp.pready |=> apb_rsp.pready) else $error("no answer");
  answer_phase_a: assert property (apb_rsp.pready |->
    $past(apb_req.psel) && $past(apb_req.penable))
    else $error("answer outside access phase");
  unmapped_err_a: assert property (apb_rsp.pready && !mapped |->
    apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (apb_rsp.pready && mapped |->
    !apb_rsp.pslverr) else $error("mapped access refused");
  upper_zero_a: assert property (apb_rsp.pready |->
    apb_rsp.prdata[31:8] == 24'h0) else $error("upper read bits set");
  read_hold_a: assert property (!apb_rsp.pready |->
    $stable(apb_rsp.prdata)) else $error("read data moved");
  data_hold_a: assert property (quiet_reg >= 4'h6 |->
    $stable(pins.serial_out_a) && $stable(pins.serial_out_b))
    else $error("serial data moved between bit edges");
  cover property (apb_rsp.pready && apb_rsp.pslverr);
  cover property (pins.serial_out_b_oe && !pins.serial_out_a_oe);
  cover property (quiet_reg == 4'h6 && pins.serial_out_a);
endmodule : serial_port_assertions
`default_nettype wire

// ### test/serial_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module serial_host_model
  import serial_port_pkg::*;
(
  output logic bit_clock,
  output logic frame_sync,
  input wire serial_pins_t pins
);
  logic cap_a [0:511];
  logic cap_b [0:511];
  initial
  begin
    bit_clock = 1'b1;
    frame_sync = 1'b1;
  end
  // Two idle bits first, so the port sees the idle sync level before a frame
  task automatic frames(input int n, input int len, input logic tdm,
    input logic bi, input logic fi);
    logic fs;
    bit_clock = ~bi;
    #250;
    for (int i = -2; i < n * len; i++)
    begin
      fs = (i < 0) ? !tdm : tdm ? (i % len == 0) : (i % len >= len / 2);
      bit_clock = bi;
      frame_sync = fs ^ fi;
      #62.5;
      bit_clock = ~bi;
      if (i >= 0)
      begin
        cap_a[i] = pins.serial_out_a_oe ? pins.serial_out_a : 1'bz;
        cap_b[i] = pins.serial_out_b_oe ? pins.serial_out_b : 1'bz;
      end
      #62.5;
    end
  endtask : frames
endmodule : serial_host_model
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/100ps
`default_nettype none
bind accel_audio_serial_port serial_port_assertions serial_port_assertions_inst
  (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .bit_clock(bit_clock), .pins(pins));
module tb
  import serial_port_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn, bit_clock, frame_sync, sample_valid, err;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  sample_t sample_in, smp;
  serial_pins_t pins;
  int n_fail = 0, check_count = 0, cyc = 0, w, d, len, sc = 0;
  int dly [5] = '{1, 0, 8, 12, 16};
  logic tdm, dual, psel_pin, hiz, fill;
  logic [2:0] slot [4];
  logic [31:0] rd;
  always #4 pclk = ~pclk;
  accel_audio_serial_port accel_audio_serial_port_inst (.pclk(pclk),
    .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .bit_clock(bit_clock), .frame_sync(frame_sync),
    .sample_valid(sample_valid), .sample_in(sample_in), .pins(pins));
  serial_host_model serial_host_model_inst (.bit_clock(bit_clock),
    .frame_sync(frame_sync), .pins(pins));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      complete_run;
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, wr, a, wd, 4'hF};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do
      @(posedge pclk);
    while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb
  // Idle bits carry no channel: floating when hi-z is on, else driven low
  function automatic logic exp_bit(input int pin, input int i, input bit fresh);
    logic r;
    int s, b, p;
    r = hiz ? 1'bz : 1'b0;
    for (int c = 0; c < 4; c++)
    begin
      s = slot[c];
      b = tdm ? d + s * w : d + (s % 2) * len / 2;
      p = dual ? (s == 2 || s == 3) : psel_pin;
      if (!tdm && !dual && s > 1)
        p = 2;
      if (p == pin && i >= b && i < b + w)
        r = (i - b < 16 && (fresh || fill)) ? smp.ch[c][15 - i + b] : 1'b0;
    end
    return r;
  endfunction : exp_bit
  task automatic run(input logic [1:0] wc, input logic [2:0] fc,
    input logic bi, fi, t, fl, hz, pp, du, input logic [11:0] sl,
    input int ln, nf);
    w = wc == 2'h1 ? 16 : wc == 2'h2 ? 24 : 32;
    d = dly[fc];
    {tdm, fill, hiz, psel_pin, dual, len} = {t, fl, hz, pp, du, ln};
    sc++;
    for (int c = 0; c < 4; c++)
    begin
      slot[c] = sl[3 * c +: 3];
      smp.ch[c] = {4'(c) ^ 4'hC, 4'(sc), 8'h5A};
    end
    apb(1'b1, 8'hC8, {24'h0, wc, bi, fi, t, fc});
    apb(1'b1, 8'hCC, {24'h0, fl, hz, sl[5:0]});
    apb(1'b1, 8'hD0, {24'h0, pp, du, sl[11:6]});
    apb(1'b0, 8'hC8, 32'h0);
    check(rd, {24'h0, wc, bi, fi, t, fc});
    sample_in <= smp;
    sample_valid <= 1'b1;
    @(posedge pclk);
    sample_valid <= 1'b0;
    serial_host_model_inst.frames(nf, ln, t, bi, fi);
    for (int i = 0; i < nf * ln; i++)
    begin
      check(serial_host_model_inst.cap_a[i], exp_bit(0, i % ln, i < ln));
      check(serial_host_model_inst.cap_b[i], exp_bit(1, i % ln, i < ln));
    end
    $display("test %0d finished", sc);
  endtask : run
  initial
  begin
    {presetn, sample_valid} = 2'h0;
    apb_req = '0;
    sample_in = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'hC8, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'hCC, 32'h0);
    check(rd, 32'h8);
    apb(1'b0, 8'hD0, 32'h0);
    check(rd, 32'h1A);
    apb(1'b0, 8'h04, 32'h0);
    check({31'h0, err}, 32'h1);
    run(2'h0, 3'h0, 0, 0, 0, 0, 0, 0, 0, 12'h688, 64, 2);
    run(2'h1, 3'h1, 0, 0, 0, 1, 0, 0, 1, 12'h443, 32, 2);
    run(2'h2, 3'h2, 1, 1, 1, 0, 1, 1, 0, 12'h42F, 192, 1);
    run(2'h1, 3'h3, 0, 0, 1, 1, 1, 0, 1, 12'h8D1, 128, 2);
    run(2'h0, 3'h4, 0, 0, 0, 0, 0, 1, 0, 12'h681, 96, 1);
    complete_run;
  end
endmodule : tb
`default_nettype wire
